// ===== verilog/aes_pkg.sv
package aes_pkg;
   // status word layout
   localparam int WORD_W = 16;
   localparam int BIT_MOVE = 0;
   localparam int BIT_FAST = 1;
   localparam int BIT_LEVEL = 2;
   localparam int BIT_GOOD = 3;
   localparam int BIT_BAD = 4;
   localparam int BIT_OVER = 5;
   localparam int BIT_RISE = 6;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // edge selection codes
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   localparam int TRAVEL_W = 32;
endpackage

// ===== verilog/aes_status.sv
`timescale 1ns/1ps
// Contract
// - move 0x1, fast event 0x2, level 0x4
// - read clears events, never the level
// - set flag means happened since read
// - move flag at actual iteration start
// - fast flag when watched input occurs
// - index axes flag on following index
// - level flag follows live input
// - fast flag sets only at tick
// - virtual axes hold level at zero
// - good mark sets bit 0x8
// - bad mark 0x10, first mark bad
// - overrun 0x20, any mark clears it
// - rising flag 0x40 holds last polarity
// - edge select fixes or alternates rising
module aes_status #(
   parameter int TRAVEL_W = aes_pkg::TRAVEL_W
) (
   input wire logic mclk, // 200 MHz clock
   input wire logic arst_n, // async reset
   input wire logic clk_en, // freezes all state when low
   input wire logic servo_tick, // servo interrupt pulse
   input wire logic move_begin, // iteration of a move starts
   input wire logic fast_in_pin, // fast input pin, async
   input wire logic index_pin, // encoder index pin, async
   input wire logic fast_watch, // axis armed for fast input
   input wire logic index_ref, // reference on index mark
   input wire logic ref_end_req, // program reference end pulse
   input wire logic virtual_axis, // network or virtual axis
   input wire logic [1:0] edge_sel, // 0 rise,1 fall,2 both
   input wire logic reg_start, // registration started pulse
   input wire logic mark_seen, // registration mark pulse
   input wire logic mark_ok, // mark judged good
   input wire logic [TRAVEL_W-1:0] travel, // travel since mark
   input wire logic [TRAVEL_W-1:0] mark_spacing, // spacing
   input wire logic [TRAVEL_W-1:0] mark_tolerance, // tolerance
   input wire logic axis_status_query, // read strobe
   output logic [15:0] axis_event_status // status word
);
   if (TRAVEL_W < 2 || TRAVEL_W > 62) begin : g_bad_width
      $error("travel width out of range");
   end

   typedef struct packed {
      logic [1:0] fin_sync;
      logic [1:0] idx_sync;
      logic fin_prev;
      logic idx_prev;
      logic edge_pend;
      logic edge_rise;
      logic idx_armed;
      logic idx_pend;
      logic first_mark;
      logic [15:0] word;
   } aes_state_t;

   aes_state_t st;
   aes_state_t next_st;
   logic fin;
   logic fin_edge;
   logic idx_edge;
   logic edge_ok;
   logic fast_evt;
   logic over_evt;
   logic [TRAVEL_W:0] limit;

   always_comb begin
      fin = st.fin_sync[1];
      fin_edge = fin ^ st.fin_prev;
      idx_edge = st.idx_sync[1] & ~st.idx_prev;
      limit = {1'b0, mark_spacing} + {1'b0, mark_tolerance};
      over_evt = {1'b0, travel} > limit;
      unique case (edge_sel)
         aes_pkg::EDGE_RISE: edge_ok = fin_edge & fin;
         aes_pkg::EDGE_FALL: edge_ok = fin_edge & ~fin;
         default: edge_ok = fin_edge;
      endcase
      next_st = st;
      next_st.fin_sync = {st.fin_sync[0], fast_in_pin};
      next_st.idx_sync = {st.idx_sync[0], index_pin};
      next_st.fin_prev = fin;
      next_st.idx_prev = st.idx_sync[1];
      if (edge_ok && fast_watch) begin
         next_st.edge_pend = 1'b1;
         next_st.edge_rise = fin;
         if (index_ref)
            next_st.idx_armed = 1'b1;
      end
      if (ref_end_req && index_ref)
         next_st.idx_armed = 1'b1;
      fast_evt = 1'b0;
      if (servo_tick) begin
         if (index_ref) begin
            fast_evt = st.idx_pend;
            if (st.idx_pend)
               next_st.idx_armed = 1'b0;
            next_st.idx_pend = 1'b0;
            next_st.edge_pend = 1'b0;
         end else begin
            fast_evt = st.edge_pend;
            next_st.edge_pend = 1'b0;
         end
      end
      if (index_ref && st.idx_armed && idx_edge && !fast_evt)
         next_st.idx_pend = 1'b1;
      // stale arming must not fire later
      if (!index_ref) begin
         next_st.idx_armed = 1'b0;
         next_st.idx_pend = 1'b0;
      end
      if (axis_status_query) begin
         next_st.word[aes_pkg::BIT_MOVE] = 1'b0;
         next_st.word[aes_pkg::BIT_FAST] = 1'b0;
         next_st.word[aes_pkg::BIT_GOOD] = 1'b0;
         next_st.word[aes_pkg::BIT_BAD] = 1'b0;
         next_st.word[aes_pkg::BIT_OVER] = 1'b0;
         next_st.word[aes_pkg::BIT_RISE] = 1'b0;
      end
      if (move_begin)
         next_st.word[aes_pkg::BIT_MOVE] = 1'b1;
      if (fast_evt) begin
         next_st.word[aes_pkg::BIT_FAST] = 1'b1;
      end
      unique case (edge_sel)
         aes_pkg::EDGE_RISE: next_st.word[aes_pkg::BIT_RISE] = 1'b1;
         aes_pkg::EDGE_FALL: next_st.word[aes_pkg::BIT_RISE] = 1'b0;
         default: next_st.word[aes_pkg::BIT_RISE] = next_st.edge_rise;
      endcase
      if (reg_start)
         next_st.first_mark = 1'b1;
      if (mark_seen) begin
         next_st.first_mark = 1'b0;
         if (st.first_mark || !mark_ok)
            next_st.word[aes_pkg::BIT_BAD] = 1'b1;
         else
            next_st.word[aes_pkg::BIT_GOOD] = 1'b1;
      end
      if (mark_seen)
         next_st.word[aes_pkg::BIT_OVER] = 1'b0;
      else if (over_evt)
         next_st.word[aes_pkg::BIT_OVER] = 1'b1;
      next_st.word[aes_pkg::BIT_LEVEL] = fin & ~virtual_axis;
      next_st.word[15:7] = 9'h000;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign axis_event_status = st.word;

   property p_move;
      @(posedge mclk) disable iff (!arst_n)
      clk_en && move_begin |=> axis_event_status[0];
   endproperty
   a_move: assert property (p_move) else $error("move flag lost");

   property p_clear;
      @(posedge mclk) disable iff (!arst_n)
      clk_en && axis_status_query && !move_begin |=> !axis_event_status[0];
   endproperty
   a_clear: assert property (p_clear) else $error("read not clear");

   property p_fast_tick;
      @(posedge mclk) disable iff (!arst_n)
      clk_en && !servo_tick && !axis_event_status[1]
         |=> !axis_event_status[1];
   endproperty
   a_fast_tick: assert property (p_fast_tick)
      else $error("fast flag off tick");

   property p_virt;
      @(posedge mclk) disable iff (!arst_n)
      clk_en && virtual_axis |=> !axis_event_status[2];
   endproperty
   a_virt: assert property (p_virt) else $error("virtual level");

   property p_upper;
      @(posedge mclk) disable iff (!arst_n)
      axis_event_status[15:7] == 9'h000;
   endproperty
   a_upper: assert property (p_upper) else $error("upper bits set");

   property p_over;
      @(posedge mclk) disable iff (!arst_n)
      clk_en && mark_seen |=> !axis_event_status[5];
   endproperty
   a_over: assert property (p_over) else $error("overrun kept");

   property p_rise0;
      @(posedge mclk) disable iff (!arst_n)
      clk_en && edge_sel == 2'h0 |=> axis_event_status[6];
   endproperty
   a_rise0: assert property (p_rise0) else $error("rise mode");

   property p_good;
      @(posedge mclk) disable iff (!arst_n)
      clk_en && mark_seen && mark_ok && !st.first_mark
         |=> axis_event_status[3];
   endproperty
   a_good: assert property (p_good) else $error("good lost");

   property p_first_bad;
      @(posedge mclk) disable iff (!arst_n)
      clk_en && mark_seen && st.first_mark |=> axis_event_status[4];
   endproperty
   a_first_bad: assert property (p_first_bad)
      else $error("first mark not bad");

   property p_set_wins;
      @(posedge mclk) disable iff (!arst_n)
      clk_en && axis_status_query && mark_seen
         |=> axis_event_status[4:3] != 2'h0;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("set lost");

   c_move: cover property (@(posedge mclk) move_begin ##1 axis_status_query);
   c_fast: cover property (@(posedge mclk) axis_event_status[1]);
   c_over: cover property (@(posedge mclk) axis_event_status[5] ##1 mark_seen);
   c_index: cover property (@(posedge mclk)
      index_ref && servo_tick && st.idx_pend);
endmodule

// ===== verification/aes_axis_far.sv
`timescale 1ns/1ps
module aes_axis_far (
   input wire logic mclk, // servo clock
   output logic fast_in_pin, // fast input level
   output logic index_pin // encoder index
);
   initial begin
      fast_in_pin = 1'b0;
      index_pin = 1'b0;
   end
   // input moves just after an edge
   task automatic set_fast(input logic v);
      @(posedge mclk);
      #1 fast_in_pin = v;
   endtask
   // one clock wide index mark
   task automatic pulse_index();
      @(posedge mclk);
      #1 index_pin = 1'b1;
      @(posedge mclk);
      #1 index_pin = 1'b0;
   endtask
endmodule

// ===== verification/tb_aes_status.sv
`timescale 1ns/1ps
module tb_aes_status;
   logic mclk, arst_n, tick, mv, watch, virt, rs, mk, ok, rd;
   logic en, iref, rend;
   logic [1:0] esel;
   logic [31:0] trav, spc, tol;
   logic fin, idx;
   logic [15:0] st;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   aes_axis_far aes_axis_far_inst (
      .mclk(mclk),
      .fast_in_pin(fin),
      .index_pin(idx)
   );
   aes_status aes_status_inst (
      .mclk(mclk),
      .arst_n(arst_n),
      .clk_en(en),
      .servo_tick(tick),
      .move_begin(mv),
      .fast_in_pin(fin),
      .index_pin(idx),
      .fast_watch(watch),
      .index_ref(iref),
      .ref_end_req(rend),
      .virtual_axis(virt),
      .edge_sel(esel),
      .reg_start(rs),
      .mark_seen(mk),
      .mark_ok(ok),
      .travel(trav),
      .mark_spacing(spc),
      .mark_tolerance(tol),
      .axis_status_query(rd),
      .axis_event_status(st)
   );
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask
   task automatic chk(input string nm, input logic [15:0] e);
      compares++;
      if (st !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, st);
      end
   endtask
   task automatic t_move();
      pulse(mv);
      step(1);
      chk("move", 16'h0041);
      pulse(rd);
      step(1);
      chk("move clr", 16'h0040);
      mv = 1'b1;
      rd = 1'b1;
      step(1);
      mv = 1'b0;
      rd = 1'b0;
      step(1);
      chk("set wins", 16'h0041);
      pulse(rd);
      step(1);
      chk("clr again", 16'h0040);
      $display("done move");
   endtask
   task automatic t_enable();
      pulse(mv);
      en = 1'b0;
      pulse(rd);
      pulse(mv);
      step(1);
      chk("frozen", 16'h0041);
      en = 1'b1;
      pulse(rd);
      step(1);
      chk("thawed", 16'h0040);
      $display("done enable");
   endtask
   task automatic t_fast();
      watch = 1'b1;
      aes_axis_far_inst.set_fast(1'b1);
      step(5);
      chk("level only", 16'h0044);
      pulse(tick);
      step(1);
      chk("fast", 16'h0046);
      pulse(rd);
      step(1);
      chk("keep level", 16'h0044);
      aes_axis_far_inst.set_fast(1'b0);
      step(5);
      pulse(tick);
      step(1);
      chk("fall refused", 16'h0040);
      esel = 2'h2;
      aes_axis_far_inst.set_fast(1'b1);
      step(5);
      pulse(tick);
      step(1);
      chk("both rise", 16'h0046);
      pulse(rd);
      aes_axis_far_inst.set_fast(1'b0);
      step(5);
      pulse(tick);
      step(1);
      chk("both fall", 16'h0002);
      esel = 2'h1;
      pulse(rd);
      step(1);
      chk("fall mode", 16'h0000);
      watch = 1'b0;
      virt = 1'b1;
      esel = 2'h0;
      aes_axis_far_inst.set_fast(1'b1);
      step(5);
      chk("virtual", 16'h0040);
      aes_axis_far_inst.set_fast(1'b0);
      virt = 1'b0;
      step(5);
      $display("done fast");
   endtask
   task automatic t_index();
      iref = 1'b1;
      watch = 1'b1;
      aes_axis_far_inst.set_fast(1'b1);
      step(5);
      pulse(tick);
      step(1);
      chk("no index yet", 16'h0044);
      aes_axis_far_inst.pulse_index();
      step(4);
      pulse(tick);
      step(1);
      chk("index", 16'h0046);
      pulse(rd);
      aes_axis_far_inst.pulse_index();
      step(4);
      pulse(tick);
      step(1);
      chk("index unarmed", 16'h0044);
      pulse(rend);
      aes_axis_far_inst.pulse_index();
      step(4);
      pulse(tick);
      step(1);
      chk("ref end", 16'h0046);
      pulse(rd);
      iref = 1'b0;
      watch = 1'b0;
      aes_axis_far_inst.set_fast(1'b0);
      step(5);
      chk("index off", 16'h0040);
      $display("done index");
   endtask
   task automatic t_mark();
      pulse(rs);
      ok = 1'b1;
      pulse(mk);
      step(1);
      chk("first bad", 16'h0050);
      pulse(rd);
      pulse(mk);
      step(1);
      chk("good", 16'h0048);
      pulse(rd);
      ok = 1'b0;
      pulse(mk);
      step(1);
      chk("bad", 16'h0050);
      pulse(rd);
      trav = 32'h00000009;
      step(3);
      chk("at limit", 16'h0040);
      trav = 32'h0000000A;
      step(3);
      chk("overrun", 16'h0060);
      trav = 32'h00000000;
      pulse(rd);
      ok = 1'b1;
      pulse(mk);
      step(1);
      chk("mark clr", 16'h0048);
      spc = 32'h00000002;
      tol = 32'h00000003;
      trav = 32'h00000006;
      step(3);
      chk("new limit", 16'h0068);
      trav = 32'h00000000;
      pulse(rd);
      step(1);
      chk("over read", 16'h0040);
      $display("done mark");
   endtask
   task automatic t_reset();
      pulse(mv);
      arst_n = 1'b0;
      step(1);
      chk("mid reset", 16'h0000);
      arst_n = 1'b1;
      step(2);
      chk("after reset", 16'h0040);
      $display("done reset");
   endtask
   initial begin
      {arst_n, tick, mv, watch, virt, rs, mk, ok, rd} = '0;
      en = 1'b1;
      iref = 1'b0;
      rend = 1'b0;
      esel = 2'h0;
      trav = 32'h00000000;
      spc = 32'h00000004;
      tol = 32'h00000005;
      repeat (6) @(posedge mclk);
      #1 chk("in reset", 16'h0000);
      arst_n = 1'b1;
      step(2);
      t_move();
      t_enable();
      t_fast();
      t_index();
      t_mark();
      t_reset();
      end_sim();
   end
endmodule
